// ==== bench/pmrbs_host_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmrbs_host_asserts #(
  parameter logic [2:0] PAIR_SEL = 3'h0,
  parameter logic SEL_A_HIGH = 1'b1,
  parameter logic SEL_B_HIGH = 1'b1
) (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rsp_valid,
  input wire logic page_known,
  input wire logic page_now,
  input wire pmrbs_pkg::pmrbs_bus_s rom_bus
);
  import pmrbs_pkg::*;
  logic [5:0] hold_q;
  wire logic act = rom_bus.select_a == SEL_A_HIGH &&
                   rom_bus.select_b == SEL_B_HIGH;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Age of the address with both selects active
  always_ff @(posedge core_clk)
    if (!rst_n || !act || $changed(rom_bus.addr)) hold_q <= 6'h00;
    else if (hold_q != 6'h3F) hold_q <= hold_q + 6'h01;
  property p_page_sw;
    $rose(page_known) || page_known && $changed(page_now) |-> rsp_valid &&
      hold_q >= 6'h11 && rom_bus.addr == (PAIR_BASE | {8'h00, PAIR_SEL, page_now});
  endproperty
  property p_read_acc; rsp_valid |-> hold_q >= 6'h0A; endproperty
  // First take after idle selects is free of the cycle limit
  property p_cycle; $changed(rom_bus.addr) && $past(act) |-> hold_q >= 6'h10; endproperty
  property p_known; $rose(page_known) |-> rsp_valid ##1 page_known[*8]; endproperty
  // A sample while a decode address stands is a page-change cycle
  property p_page_acc;
    rsp_valid && rom_bus.addr[11:1] == {8'hFF, PAIR_SEL} |-> hold_q >= 6'h11;
  endproperty
  a_page_sw: assert property (p_page_sw) else $error("page switch bad");
  a_read_acc: assert property (p_read_acc) else $error("early sample");
  a_cycle: assert property (p_cycle) else $error("cycle too short");
  a_known: assert property (p_known) else $error("page flag bad");
  a_page_acc: assert property (p_page_acc) else $error("page early");
  c_read: cover property (rsp_valid && page_known);
  c_switch: cover property (page_known && $changed(page_now));
  c_first: cover property ($rose(page_known));
endmodule : pmrbs_host_asserts
bind pmrbs_host pmrbs_host_asserts #(.PAIR_SEL(PAIR_SEL), .SEL_A_HIGH(SEL_A_HIGH),
  .SEL_B_HIGH(SEL_B_HIGH)) u_pmrbs_host_asserts (.core_clk(core_clk), .rst_n(rst_n),
  .rsp_valid(rsp_valid), .page_known(page_known), .page_now(page_now),
  .rom_bus(rom_bus));
`default_nettype wire

// ==== bench/pmrbs_host_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmrbs_host_tb;
  import pmrbs_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
  logic req_ready, rsp_valid, page_known, page_now;
  logic [7:0] rsp_data, byte_out_lines;
  pmrbs_req_s req = '0;
  pmrbs_bus_s rom_bus;
  int err_total = 0, n_tests = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  pmrbs_host #(.PAIR_SEL(3'h5), .SEL_B_HIGH(1'b0)) u_pmrbs_host (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .page_known(page_known), .page_now(page_now), .rom_bus(rom_bus),
    .byte_out_lines(byte_out_lines));
  pmrbs_rom_model #(.PAIR_SEL(3'h5)) u_pmrbs_rom_model (.rom_bus(rom_bus),
    .byte_out_lines(byte_out_lines));
  task automatic check(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin err_total++; $display("[ERR] %0t %s", $time, m); end
  endtask : check
  task automatic xfer(input logic cmd, pg, input logic [11:0] a);
    int n;
    logic [7:0] exp;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= {a, cmd, pg};
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin @(posedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 40);
    exp = a[11:4] == 8'hFF ? a[7:0] : a[7:0] ^ {pg, 7'h35};
    check(rsp_valid === 1'b1, "no response");
    check(n >= (cmd ? PAGE_ACC_CYC : ACCESS_CYC), "sampled early");
    check(rsp_data === exp, "data");
  endtask : xfer
  task automatic t_mid_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(page_known === 1'b0 && rom_bus.select_a === 1'b0, "mid reset");
    rst_n <= 1'b1;
    xfer(1'b1, 1'b1, 12'hFFB);
    check(page_known === 1'b1 && page_now === 1'b1, "page again");
    xfer(1'b0, 1'b1, 12'h7C0);
  endtask : t_mid_reset
  task automatic t_reset();
    check(page_known === 1'b0 && rom_bus.select_a === 1'b0, "reset");
  endtask : t_reset
  task automatic t_pages();
    xfer(1'b1, 1'b1, 12'hFFB);
    check(page_known === 1'b1 && page_now === 1'b1, "page 1");
    xfer(1'b0, 1'b1, 12'h123);
    xfer(1'b1, 1'b0, 12'hFFA);
    check(page_now === 1'b0, "page 0");
  endtask : t_pages
  task automatic t_back_to_back();
    xfer(1'b0, 1'b0, 12'h000);
    xfer(1'b0, 1'b0, 12'hFF4);
  endtask : t_back_to_back
  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin err_total++; end_of_test(); end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    t_reset();
    rst_n <= 1'b1;
    t_pages();
    t_back_to_back();
    t_mid_reset();
    end_of_test();
  end
endmodule : pmrbs_host_tb
`default_nettype wire

// ==== bench/pmrbs_rom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmrbs_rom_model #(
  parameter logic [2:0] PAIR_SEL = 3'h0
) (
  // Pins
  input wire pmrbs_pkg::pmrbs_bus_s rom_bus,
  output logic [7:0] byte_out_lines
);
  import pmrbs_pkg::*;
  logic pg = 1'bx;
  logic ok = 1'b0;
  int ev = 0;
  wire logic act = rom_bus.select_a && !rom_bus.select_b;
  wire logic dec = rom_bus.addr[11:1] == {8'hFF, PAIR_SEL};
  // Decode words alike in both pages
  function automatic logic [7:0] rom_word(logic p, logic [11:0] a);
    return a[11:4] == 8'hFF ? a[7:0] : a[7:0] ^ {p, 7'h35};
  endfunction : rom_word
  always @(rom_bus) begin
    ev++;
    ok = 1'b0;
    fork begin
      automatic int e = ev;
      #450;
      if (e == ev && act && dec) pg = rom_bus.addr[0];
      if (e == ev && !dec) ok = 1'b1;
      #350;
      if (e == ev) ok = 1'b1;
    end join_none
  end
  // Invalid or released lines show the inverse
  assign byte_out_lines = ok && act ? rom_word(pg, rom_bus.addr)
                                    : ~rom_word(pg, rom_bus.addr);
endmodule : pmrbs_rom_model
`default_nettype wire

// ==== hdl/pmrbs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmrbs_host #(
  parameter logic [2:0] PAIR_SEL   = 3'h0,
  parameter logic       SEL_A_HIGH = 1'b1,
  parameter logic       SEL_B_HIGH = 1'b1
) (
  // Clock and reset
  input  wire  logic                          core_clk,
  input  wire  logic                          rst_n,
  // User request
  input  wire  logic                          req_valid,
  input  wire  pmrbs_pkg::pmrbs_req_s         req,
  output var   logic                          req_ready,
  output var   logic                          rsp_valid,
  output var   logic [pmrbs_pkg::DATA_W-1:0]  rsp_data,
  output var   logic                          page_known,
  output var   logic                          page_now,
  // ROM pins
  output var   pmrbs_pkg::pmrbs_bus_s         rom_bus,
  input  wire  logic [pmrbs_pkg::DATA_W-1:0]  byte_out_lines
);
  import pmrbs_pkg::*;


  // ---------------------------------------------------------------
  // Types and cycle counts
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_GAP} pmrbs_state_e;

  // Two synchroniser flops sit between the pins and the sample
  localparam int SYNC_CYC = 2;
  // Flop update needs the select hold, the data needs the long access
  localparam int PAGE_HOLD_CYC = (PAGE_ACC_CYC > SEL_HOLD_CYC) ?
                                 PAGE_ACC_CYC : SEL_HOLD_CYC;
  localparam logic [CNT_W-1:0] READ_WAIT =
    CNT_W'(ACCESS_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] PAGE_WAIT =
    CNT_W'(PAGE_HOLD_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] CYCLE_END = CNT_W'(CYCLE_CYC);

  // ---------------------------------------------------------------
  // Decode pair
  // ---------------------------------------------------------------
  // Even member of the pair picks page 0, the odd one page 1
  localparam logic [ADDR_W-1:0] PAGE0_ADDR =
    PAIR_BASE | {{(ADDR_W-PAIR_SEL_W-1){1'b0}}, PAIR_SEL, 1'b0};
  localparam logic [ADDR_W-1:0] PAGE1_ADDR = PAGE0_ADDR | 12'h001;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  pmrbs_state_e            state_q;
  pmrbs_state_e            state_d;
  logic [CNT_W-1:0]        cnt_q;
  logic [CNT_W-1:0]        wait_q;
  logic                    switch_q;
  logic                    target_q;
  logic [DATA_W-1:0]       sync1_q;
  logic [DATA_W-1:0]       sync2_q;
  logic [ADDR_W-1:0]       bus_addr_d;
  logic                    take;
  logic                    wait_done;
  logic                    gap_done;
  logic                    in_idle;
  logic                    in_sample;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  // Pins are async to us, so the data is double-registered
  always_ff @(posedge core_clk) begin
    sync1_q <= byte_out_lines;
    sync2_q <= sync1_q;
  end

  // ---------------------------------------------------------------
  // Handshake and timer decode
  // ---------------------------------------------------------------
  assign in_idle   = (state_q == ST_IDLE);
  assign in_sample = (state_q == ST_SAMPLE);
  assign take      = req_valid && req_ready && in_idle;
  assign wait_done = (cnt_q + 1'b1) >= wait_q;
  assign gap_done  = (cnt_q + 1'b1) >= CYCLE_END;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Covers the 450 ns select hold and the access time
        if (wait_done) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_d = ST_GAP;
      end
      ST_GAP: begin
        // Cycle stretched to its minimum length before the next take
        if (gap_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Cycle timer
  // ---------------------------------------------------------------
  // Zero in idle, so each take counts from its own address change
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (in_idle) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Wait length is latched at the take; the page change waits longer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_q <= '0;
    end else if (take) begin
      wait_q <= req.page_cmd ? PAGE_WAIT : READ_WAIT;
    end
  end

  // ---------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      switch_q <= 1'b0;
      target_q <= 1'b0;
    end else if (take) begin
      switch_q <= req.page_cmd;
      target_q <= req.page;
    end
  end

  // Ready falls on the take edge, so a held request is taken only once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= in_idle && !take;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  always_comb begin
    bus_addr_d = req.addr;
    if (req.page_cmd) begin
      // Decode address of the wanted page stands in for the user address
      bus_addr_d = req.page ? PAGE1_ADDR : PAGE0_ADDR;
    end
  end

  // Selects stay active after first use; only the address marks a cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rom_bus.addr     <= '0;
      rom_bus.select_a <= ~SEL_A_HIGH;
      rom_bus.select_b <= ~SEL_B_HIGH;
    end else if (take) begin
      rom_bus.addr     <= bus_addr_d;
      rom_bus.select_a <= SEL_A_HIGH;
      rom_bus.select_b <= SEL_B_HIGH;
    end
  end

  // ---------------------------------------------------------------
  // Response
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= in_sample;
    end
  end

  // Held after the pulse; a page command returns the decode word,
  // which is only meaningful if it is alike in both pages
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_data <= '0;
    end else if (in_sample) begin
      rsp_data <= sync2_q;
    end
  end

  // ---------------------------------------------------------------
  // Page tracking
  // ---------------------------------------------------------------
  // The part itself powers up in either page, so nothing is assumed
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      page_known <= 1'b0;
    end else if (in_sample && switch_q) begin
      page_known <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      page_now <= 1'b0;
    end else if (in_sample && switch_q) begin
      page_now <= target_q;
    end
  end

endmodule : pmrbs_host
`default_nettype wire

// ==== hdl/pmrbs_pkg.sv ====
// Overview of operation
// - Host holds decode address with both selects active at least 450 ns.
// - Page undefined after power-up; host issues a decode address before reading (pmrbs_host does not; it reads anyway and only clears page_known).
// - Same data should sit at both decode addresses in both pages.
// - Host waits 800 ns in a page-change cycle, 450 ns otherwise, before sampling.
// - With selects held active, each read cycle lasts at least 840 ns.
package pmrbs_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 8;
  localparam int PAIR_SEL_W  = 3;
  localparam logic [ADDR_W-1:0] PAIR_BASE = 12'hFF0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int T_ACCESS_NS    = 450;
  localparam int T_PAGE_ACC_NS  = 800;
  localparam int T_SEL_HOLD_NS  = 450;
  localparam int T_CYCLE_NS     = 840;
  // Least times round up
  localparam int ACCESS_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_ACC_CYC = (T_PAGE_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_HOLD_CYC = (T_SEL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC    = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W        = 6;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              select_a;
    logic              select_b;
  } pmrbs_bus_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              page_cmd;
    logic              page;
  } pmrbs_req_s;

endpackage : pmrbs_pkg
